// ### rtl/pts_cfg.svh
// Register offsets, reset values and encodings of the period timer
`ifndef PTS_CFG_SVH
`define PTS_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define PTS_OFF_COUNT    3'h0
`define PTS_OFF_MATCH    3'h1
`define PTS_OFF_CTRL     3'h2
`define PTS_OFF_LIMIT    3'h3
`define PTS_OFF_CLKSEL   3'h4
`define PTS_OFF_RSTSEL   3'h5
`define PTS_OFF_STATUS   3'h6

// ****************************************
// Reset values
// ****************************************
`define PTS_COUNT_RST    8'h00
`define PTS_MATCH_RST    8'hFF
`define PTS_CTRL_RST     8'h00
`define PTS_LIMIT_RST    5'h00
`define PTS_SEL_RST      5'h00

// ****************************************
// Clock source codes and field positions
// ****************************************
`define PTS_CS_PIN       5'h00
`define PTS_CS_FOSC4     5'h01
`define PTS_CS_FOSC      5'h02
`define PTS_CS_OSC_LAST  5'h07
`define PTS_CS_ZCD       5'h08
`define PTS_CS_CELL_1    5'h10
`define PTS_CS_CELL_8    5'h17
`define PTS_FOSC4_LAST   2'h3
`define PTS_ST_FLAG      0
`define PTS_ST_IRQ_EN    1

`endif

// ### rtl/pts_pkg.sv
// Types shared by the period timer
package pts_pkg;
   typedef enum logic [1:0] {
      op_free,
      op_one_shot,
      op_mono,
      op_spare
   } pts_op_t;

   typedef struct packed {
      logic       on;
      logic [2:0] prescale_select;
      logic [3:0] postscale_select;
   } pts_ctrl_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } pts_bus_t;
endpackage

// ### rtl/pts_timer.sv
// Period timer with prescaler, period match and postscaler
`timescale 1ns/1ps
`include "pts_cfg.svh"

// Functional notes
// - Prescaler divides 1:1 up to 1:128
// - Postscaler divides period matches 1:1 to 1:16
// - Five-bit code selects timer clock source
// - Counter increments on each prescaled clock
// - Match signals postscaler, counter clears next clock
// - Postscale hit gives one-clock pulse, clears count
// - Gate modes hold count while gate inactive
// - Reset modes clear counter on level/edge
// - Reset clears counter, match value becomes FFh
// - Several events clear prescaler and postscaler
// - Control write leaves counter unchanged
// - Counter and match value readable and writable
// - One-shot clears enable and stops at match
// - One-shot ignores nonzero postscale select
// - Monostable stops, keeps enable, restarts externally
// - Period signal delivered to PWM unit
// - Selected external reset starts, stops, resets
// - Flag on postscale match, irq when enabled
// - External triggers ignored in debug mode
module pts_timer
   import pts_pkg::*;
(
   input  wire logic        ref_clk_in,
   input  wire logic        reset_in,
   input  wire pts_bus_t    bus_in,
   output logic      [7:0]  rdata_out,
   input  wire logic        clk_pin_in,
   input  wire logic [4:0]  osc_src_in,
   input  wire logic        zero_cross_in,
   input  wire logic [7:0]  logic_cell_in,
   input  wire logic [31:0] ext_reset_src_in,
   input  wire logic        debug_mode_in,
   output logic             postscaled_out,
   output logic             period_out,
   output logic             irq_out
);

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0]  period_counter_reg, period_match_value_reg, rdata_reg;
   pts_ctrl_t   timer_control_reg;
   logic [4:0]  limit_timer_control_reg, clk_sel_reg, reset_source_select_reg;
   logic [6:0]  pre_cnt_reg;
   logic [3:0]  ps_cnt_reg;
   logic [1:0]  fosc4_reg;
   logic [14:0] clk_s1_reg, clk_s2_reg;
   logic [31:0] ers_s1_reg, ers_s2_reg;
   logic        irq_flag_reg, irq_en_reg, stopped_reg, clk_s3_reg;
   logic        ers_lvl_reg, ers_prev_reg, postscaled_reg, period_reg, irq_reg;

   logic        src_async, tclk_tick, cs_valid, run, pre_done, timer_tick, match, ps_hit;
   logic        gate_ok, ers_rise, ers_fall, rst_evt, rst_lvl, start_evt, ext_clear;
   logic        wr_count, wr_ctrl, flag_set, irq_flag_next;
   pts_op_t     op;
   logic [2:0]  trig;

   function automatic logic wr_at(input pts_bus_t b, input logic [2:0] a);
      return b.wr && (b.addr == a);
   endfunction

   // Mask of prescaler bits that must all be one to emit a tick
   function automatic logic [6:0] pre_mask(input logic [2:0] sel);
      return 7'(8'h7F >> (3'h7 - sel));
   endfunction

   assign wr_count = wr_at(bus_in, `PTS_OFF_COUNT);
   assign wr_ctrl  = wr_at(bus_in, `PTS_OFF_CTRL);
   assign op       = pts_op_t'(limit_timer_control_reg[4:3]);
   assign trig     = limit_timer_control_reg[2:0];

   // ****************************************
   // Clock source selection
   // ****************************************
   always_comb begin
      src_async = 1'b0;
      cs_valid  = 1'b1;
      if (clk_sel_reg == `PTS_CS_PIN) begin
         src_async = clk_s2_reg[0];
      end else if (clk_sel_reg > `PTS_CS_FOSC && clk_sel_reg <= `PTS_CS_OSC_LAST) begin
         src_async = clk_s2_reg[4'(clk_sel_reg - `PTS_CS_FOSC)];
      end else if (clk_sel_reg == `PTS_CS_ZCD) begin
         src_async = clk_s2_reg[6];
      end else if (clk_sel_reg >= `PTS_CS_CELL_1 && clk_sel_reg <= `PTS_CS_CELL_8) begin
         src_async = clk_s2_reg[4'h7 + 4'(clk_sel_reg[2:0])];
      end else if (clk_sel_reg != `PTS_CS_FOSC && clk_sel_reg != `PTS_CS_FOSC4) begin
         cs_valid = 1'b0;
      end
   end

   // Sources are synchronised before the mux; each must run below a quarter of ref_clk_in
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         clk_s1_reg <= 15'h0000;
         clk_s2_reg <= 15'h0000;
         clk_s3_reg <= 1'b0;
         fosc4_reg  <= 2'h0;
      end else begin
         clk_s1_reg <= {logic_cell_in, zero_cross_in, osc_src_in, clk_pin_in};
         clk_s2_reg <= clk_s1_reg;
         clk_s3_reg <= src_async;
         fosc4_reg  <= fosc4_reg + 2'h1;
      end
   end

   always_comb begin
      if (clk_sel_reg == `PTS_CS_FOSC) begin
         tclk_tick = 1'b1;
      end else if (clk_sel_reg == `PTS_CS_FOSC4) begin
         tclk_tick = (fosc4_reg == `PTS_FOSC4_LAST);
      end else begin
         tclk_tick = cs_valid && src_async && !clk_s3_reg;
      end
   end

   // ****************************************
   // External reset source
   // ****************************************
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         ers_s1_reg   <= 32'h0000_0000;
         ers_s2_reg   <= 32'h0000_0000;
         ers_lvl_reg  <= 1'b0;
         ers_prev_reg <= 1'b0;
      end else begin
         ers_s1_reg   <= ext_reset_src_in;
         ers_s2_reg   <= ers_s1_reg;
         if (!debug_mode_in) begin
            ers_lvl_reg <= ers_s2_reg[reset_source_select_reg];
         end
         ers_prev_reg <= ers_lvl_reg;
      end
   end

   assign ers_rise = ers_lvl_reg && !ers_prev_reg;
   assign ers_fall = !ers_lvl_reg && ers_prev_reg;

   // Low mode bits pick gating, edge reset or level reset
   always_comb begin
      gate_ok   = 1'b1;
      rst_evt   = 1'b0;
      rst_lvl   = 1'b0;
      start_evt = 1'b0;
      if (op == op_mono) begin
         case (trig[1:0])
            2'h1:    start_evt = ers_rise;
            2'h2:    start_evt = ers_fall;
            2'h3:    start_evt = ers_rise || ers_fall;
            default: start_evt = 1'b0;
         endcase
      end else begin
         case (trig)
            3'h1:    gate_ok = ers_lvl_reg;
            3'h2:    gate_ok = !ers_lvl_reg;
            3'h3:    rst_evt = ers_rise || ers_fall;
            3'h4:    rst_evt = ers_rise;
            3'h5:    rst_evt = ers_fall;
            3'h6:    rst_lvl = !ers_lvl_reg;
            3'h7:    rst_lvl = ers_lvl_reg;
            default: gate_ok = 1'b1;
         endcase
      end
   end

   assign ext_clear = timer_control_reg.on && (rst_evt || rst_lvl || start_evt);

   // ****************************************
   // Prescaler, counter and postscaler
   // ****************************************
   assign run        = timer_control_reg.on && !stopped_reg && gate_ok && !rst_lvl;
   assign pre_done   = (pre_cnt_reg == pre_mask(timer_control_reg.prescale_select));
   assign timer_tick = tclk_tick && run && pre_done && !ext_clear;
   assign match      = (period_counter_reg == period_match_value_reg);
   // One-shot stops at its first match, so the postscale value is moot there
   assign ps_hit     = (op == op_one_shot)
                       || (ps_cnt_reg == timer_control_reg.postscale_select);
   assign flag_set   = timer_tick && match && ps_hit;

   always_ff @(posedge ref_clk_in) begin
      if (reset_in || wr_count || wr_ctrl || ext_clear) begin
         pre_cnt_reg <= 7'h00;
      end else if (tclk_tick && run) begin
         pre_cnt_reg <= pre_done ? 7'h00 : pre_cnt_reg + 7'h01;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in || wr_count || wr_ctrl || ext_clear) begin
         ps_cnt_reg <= 4'h0;
      end else if (timer_tick && match) begin
         ps_cnt_reg <= ps_hit ? 4'h0 : ps_cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         period_counter_reg <= `PTS_COUNT_RST;
      end else if (wr_count) begin
         period_counter_reg <= bus_in.wdata;
      end else if (ext_clear) begin
         period_counter_reg <= 8'h00;
      end else if (timer_tick) begin
         period_counter_reg <= match ? 8'h00 : period_counter_reg + 8'h01;
      end
   end

   // Pulses stand for one timer clock, from one tick to the next, but end at once when the timer is off
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         postscaled_reg <= 1'b0;
         period_reg     <= 1'b0;
      end else if (timer_tick) begin
         postscaled_reg <= match && ps_hit;
         period_reg     <= match;
      end else if (tclk_tick || !timer_control_reg.on) begin
         postscaled_reg <= 1'b0;
         period_reg     <= 1'b0;
      end
   end

   // ****************************************
   // Control and mode
   // ****************************************
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         timer_control_reg <= pts_ctrl_t'(`PTS_CTRL_RST);
      end else if (wr_ctrl) begin
         timer_control_reg <= pts_ctrl_t'(bus_in.wdata);
      end else if (op == op_one_shot && timer_tick && match) begin
         timer_control_reg.on <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         stopped_reg <= 1'b0;
      end else if (wr_ctrl && !bus_in.wdata[7]) begin
         stopped_reg <= 1'b0;
      end else if (start_evt && timer_control_reg.on) begin
         stopped_reg <= 1'b0;
      end else if ((op == op_one_shot || op == op_mono) && timer_tick && match) begin
         stopped_reg <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         period_match_value_reg  <= `PTS_MATCH_RST;
         limit_timer_control_reg <= `PTS_LIMIT_RST;
         clk_sel_reg             <= `PTS_SEL_RST;
         reset_source_select_reg <= `PTS_SEL_RST;
         irq_en_reg              <= 1'b0;
      end else if (bus_in.wr) begin
         if (bus_in.addr == `PTS_OFF_MATCH) begin
            period_match_value_reg <= bus_in.wdata;
         end else if (bus_in.addr == `PTS_OFF_LIMIT) begin
            limit_timer_control_reg <= bus_in.wdata[4:0];
         end else if (bus_in.addr == `PTS_OFF_CLKSEL) begin
            clk_sel_reg <= bus_in.wdata[4:0];
         end else if (bus_in.addr == `PTS_OFF_RSTSEL) begin
            reset_source_select_reg <= bus_in.wdata[4:0];
         end else if (bus_in.addr == `PTS_OFF_STATUS) begin
            irq_en_reg <= bus_in.wdata[`PTS_ST_IRQ_EN];
         end
      end
   end

   // ****************************************
   // Interrupt flag and read port
   // ****************************************
   // A new hit in the clearing cycle keeps the flag set
   assign irq_flag_next = flag_set || (irq_flag_reg
                          && !(wr_at(bus_in, `PTS_OFF_STATUS) && bus_in.wdata[`PTS_ST_FLAG]));

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         irq_flag_reg <= 1'b0;
         irq_reg      <= 1'b0;
      end else begin
         irq_flag_reg <= irq_flag_next;
         irq_reg      <= irq_flag_next && irq_en_reg;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in || !bus_in.rd) begin
         rdata_reg <= 8'h00;
      end else if (bus_in.addr == `PTS_OFF_COUNT) begin
         rdata_reg <= period_counter_reg;
      end else if (bus_in.addr == `PTS_OFF_MATCH) begin
         rdata_reg <= period_match_value_reg;
      end else if (bus_in.addr == `PTS_OFF_CTRL) begin
         rdata_reg <= timer_control_reg;
      end else if (bus_in.addr == `PTS_OFF_LIMIT) begin
         rdata_reg <= {3'h0, limit_timer_control_reg};
      end else if (bus_in.addr == `PTS_OFF_CLKSEL) begin
         rdata_reg <= {3'h0, clk_sel_reg};
      end else if (bus_in.addr == `PTS_OFF_RSTSEL) begin
         rdata_reg <= {3'h0, reset_source_select_reg};
      end else if (bus_in.addr == `PTS_OFF_STATUS) begin
         rdata_reg <= {4'h0, stopped_reg, ers_lvl_reg, irq_en_reg, irq_flag_reg};
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   assign rdata_out      = rdata_reg;
   assign postscaled_out = postscaled_reg;
   assign period_out     = period_reg;
   assign irq_out        = irq_reg;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);

   a_match_reset_ff: assert property (@(posedge ref_clk_in) disable iff (1'b0) reset_in |=>
      period_match_value_reg == 8'hFF && period_counter_reg == 8'h00)
      else $error("match value or counter wrong after reset");
   a_count_step: assert property (timer_tick && !match && !wr_count
      |=> period_counter_reg == $past(period_counter_reg) + 8'h01)
      else $error("counter did not step on timer tick");
   a_match_wrap: assert property (timer_tick && match && !wr_count
      |=> period_counter_reg == 8'h00 && period_out)
      else $error("counter did not clear after match");
   a_ctrl_keeps: assert property (wr_ctrl && !wr_count && !ext_clear && !timer_tick
      |=> $stable(period_counter_reg))
      else $error("control write changed counter");
   a_scalers_clear: assert property (wr_count || wr_ctrl || ext_clear
      |=> pre_cnt_reg == 7'h00 && ps_cnt_reg == 4'h0)
      else $error("scalers not cleared");
   a_one_shot_off: assert property (op == op_one_shot && timer_tick && match && !wr_ctrl
      |=> !timer_control_reg.on && postscaled_out)
      else $error("one-shot did not stop with pulse");
   a_pulse_hold: assert property (postscaled_out && !tclk_tick && timer_control_reg.on
      |=> postscaled_out)
      else $error("postscaled pulse shorter than a timer clock");
   a_gate_hold: assert property (!gate_ok && !wr_count && !ext_clear
      |=> $stable(period_counter_reg))
      else $error("counter moved with gate closed");
   a_irq_gate: assert property (irq_out |-> $past(irq_en_reg))
      else $error("interrupt without enable");
   a_debug_freeze: assert property (debug_mode_in |=> $stable(ers_lvl_reg))
      else $error("trigger changed in debug mode");
   a_reserved_idle: assert property ((clk_sel_reg > `PTS_CS_CELL_8 || (clk_sel_reg > `PTS_CS_ZCD
      && clk_sel_reg < `PTS_CS_CELL_1)) && !wr_count && !ext_clear |=> $stable(period_counter_reg))
      else $error("reserved clock code moved counter");
   a_mono_hold: assert property (op == op_mono && stopped_reg && !start_evt
      && !wr_ctrl |=> timer_control_reg.on == $past(timer_control_reg.on) && stopped_reg)
      else $error("monostable left stop without event");

   c_one_shot: cover property (op == op_one_shot && timer_tick && match);
   c_post_pulse: cover property ($rose(postscaled_out) && ps_cnt_reg == 4'h0);
   c_mono_restart: cover property (op == op_mono && stopped_reg && start_evt);
   c_level_reset: cover property (rst_lvl && timer_control_reg.on);

endmodule

// ### sim/pts_consumer.sv
// Peripheral model that takes in the timer pulses and counts them
`timescale 1ns/1ps
module pts_consumer (
   input  wire logic ref_clk_in,
   input  wire logic reset_in,
   input  wire logic postscaled_in,
   input  wire logic period_in,
   output int        post_cnt_out,
   output int        per_cnt_out
);
   logic post_reg;
   logic per_reg;

   // Rising edges only: a pulse held over several cycles is one event
   always_ff @(posedge ref_clk_in) begin
      post_reg <= postscaled_in;
      per_reg <= period_in;
      if (reset_in) begin
         post_cnt_out <= 0;
         per_cnt_out <= 0;
      end else begin
         post_cnt_out <= post_cnt_out + int'(postscaled_in && !post_reg);
         per_cnt_out <= per_cnt_out + int'(period_in && !per_reg);
      end
   end
endmodule

// ### sim/period_timer_with_pre_post_scaler_tb.sv
// Self-checking bench for the period timer
`timescale 1ns/1ps
`include "pts_cfg.svh"
module period_timer_with_pre_post_scaler_tb
   import pts_pkg::*;
;
   logic        clk, rst, dbg, post, per, irq;
   logic        pin = 1'b0;
   logic [1:0]  pdiv = 2'h0;
   logic [7:0]  rdata, d, v;
   logic [31:0] ers;
   pts_bus_t    bus;
   int          fails, tests_run, w, m, p, n, q0, c0, pc, qc;
   logic [4:0]  cs [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h07, 5'h08, 5'h10, 5'h17, 5'h18};
   int          sp [9] = '{8, 4, 1, 8, 8, 8, 8, 8, 0};
   logic [4:0]  lm [4] = '{5'h01, 5'h02, 5'h06, 5'h07};
   logic [3:0]  lh = 4'hA;

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Slow outside source: one rising edge every 8 cycles on every clock source input
   always @(posedge clk) begin
      pdiv <= pdiv + 2'h1;
      if (pdiv == 2'h3) begin
         pin <= ~pin;
      end
   end

   pts_timer u_dut (
      .ref_clk_in       (clk),
      .reset_in         (rst),
      .bus_in           (bus),
      .rdata_out        (rdata),
      .clk_pin_in       (pin),
      .osc_src_in       ({5{pin}}),
      .zero_cross_in    (pin),
      .logic_cell_in    ({8{pin}}),
      .ext_reset_src_in (ers),
      .debug_mode_in    (dbg),
      .postscaled_out   (post),
      .period_out       (per),
      .irq_out          (irq)
   );

   pts_consumer u_peer (
      .ref_clk_in    (clk),
      .reset_in      (rst),
      .postscaled_in (post),
      .period_in     (per),
      .post_cnt_out  (pc),
      .per_cnt_out   (qc)
   );

   // ****************************************
   // Helpers
   // ****************************************
   function automatic int exp_gap(int s, int ps, int mt, int po);
      return s * (1 << ps) * (mt + 1) * (po + 1);
   endfunction

   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] x);
      @(posedge clk);
      bus <= '{1'b1, 1'b0, a, x};
      @(posedge clk);
      bus <= '0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] x);
      @(posedge clk);
      bus <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk);
      bus <= '0;
      #1 x = rdata;
   endtask

   task automatic chk(input logic [2:0] a, input logic [7:0] e, input string nm);
      rd(a, d);
      cmp(nm, 32'(e), 32'(d));
   endtask

   task automatic setup(input logic [4:0] c, input int mt, input int ps, input int po);
      wr(`PTS_OFF_CTRL, 8'h00);
      wr(`PTS_OFF_CLKSEL, {3'h0, c});
      wr(`PTS_OFF_MATCH, 8'(mt));
      wr(`PTS_OFF_COUNT, 8'h00);
      wr(`PTS_OFF_CTRL, {1'b1, 3'(ps), 4'(po)});
   endtask

   // Cycles between two rises of one pulse, sampled on the settled falling edge
   task automatic meas(input logic sel, input int e, input string nm);
      int   k, r, g;
      logic s, s1;
      r = 0;
      g = 0;
      s1 = 1'b1;
      for (k = 0; k < 3 * e + 200 && r < 2; k++) begin
         @(negedge clk);
         s = sel ? post : per;
         r += int'(s && !s1);
         g += int'(r == 1);
         s1 = s;
      end
      cmp(nm, e, (r == 2) ? g : 0);
   endtask

   // Held and spaced far longer than the trigger minimums
   task automatic pulse_ers();
      @(posedge clk);
      ers[3] <= 1'b1;
      repeat (10) @(posedge clk);
      ers[3] <= 1'b0;
      repeat (10) @(posedge clk);
   endtask

   task automatic results();
      $display("tests_run %0d fails %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      bus = '0;
      rst = 1'b1;
      ers = '0;
      dbg = 1'b0;
      fails = 0;
      tests_run = 0;
      void'($urandom(92745));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk(`PTS_OFF_COUNT, `PTS_COUNT_RST, "count");
      chk(`PTS_OFF_MATCH, `PTS_MATCH_RST, "match");
      chk(3'h7, 8'h00, "unmapped");
      repeat (4) begin
         v = 8'($urandom);
         wr(`PTS_OFF_MATCH, v);
         wr(`PTS_OFF_COUNT, ~v);
         chk(`PTS_OFF_MATCH, v, "match rw");
         chk(`PTS_OFF_COUNT, ~v, "count rw");
      end
      setup(5'h18, 3, 0, 0);
      wr(`PTS_OFF_COUNT, 8'h5A);
      repeat (20) @(posedge clk);
      wr(`PTS_OFF_CTRL, 8'hF7);
      chk(`PTS_OFF_COUNT, 8'h5A, "count held");
      $display("test registers done");
      for (int i = 0; i < 9; i++) begin
         m = 1 + $urandom % 6;
         p = $urandom % 4;
         n = $urandom % 3;
         setup(cs[i], m, n, p);
         meas(1'b0, exp_gap(sp[i], n, m, 0), "period gap");
         for (w = 0; per === 1'b1 && w < 300; w++) @(negedge clk);
         cmp("pulse width", sp[i], w);
         meas(1'b1, exp_gap(sp[i], n, m, p), "postscaled gap");
      end
      $display("test sources done");
      for (int k = 0; k < 16; k++) begin
         setup(`PTS_CS_FOSC, 1, k % 8, k);
         meas(1'b0, exp_gap(1, k % 8, 1, 0), "prescaled gap");
         meas(1'b1, exp_gap(1, k % 8, 1, k), "postscaled gap");
      end
      $display("test scalers done");
      wr(`PTS_OFF_STATUS, 8'h02);
      setup(`PTS_CS_FOSC, 2, 0, 0);
      meas(1'b1, 3, "irq gap");
      repeat (2) @(posedge clk);
      cmp("irq raised", 1, irq);
      wr(`PTS_OFF_CTRL, 8'h00);
      wr(`PTS_OFF_STATUS, 8'h03);
      rd(`PTS_OFF_STATUS, d);
      cmp("flag cleared", 2'h2, d[1:0]);
      cmp("irq low", 0, irq);
      wr(`PTS_OFF_STATUS, 8'h00);
      wr(`PTS_OFF_CTRL, 8'h80);
      repeat (20) @(posedge clk);
      rd(`PTS_OFF_STATUS, d);
      cmp("flag masked", 2'h1, d[1:0]);
      cmp("irq masked", 0, irq);
      $display("test irq done");
      // Stop the free run first so its last pulses are counted before the baseline
      wr(`PTS_OFF_CTRL, 8'h00);
      wr(`PTS_OFF_LIMIT, 8'h08);
      for (int k = 0; k < 2; k++) begin
         q0 = pc;
         c0 = qc;
         setup(`PTS_CS_FOSC, 4, 0, 3);
         repeat (40) @(posedge clk);
         cmp("one shot pulses", q0 + 1, pc);
         cmp("one shot periods", c0 + 1, qc);
         chk(`PTS_OFF_CTRL, 8'h03, "on cleared");
      end
      $display("test one-shot done");
      wr(`PTS_OFF_RSTSEL, 8'h03);
      wr(`PTS_OFF_LIMIT, 8'h11);
      setup(`PTS_CS_FOSC, 4, 0, 0);
      repeat (40) @(posedge clk);
      for (int k = 0; k < 2; k++) begin
         c0 = qc;
         pulse_ers();
         repeat (40) @(posedge clk);
         cmp("mono restart", c0 + 1, qc);
      end
      chk(`PTS_OFF_CTRL, 8'h80, "on kept");
      $display("test monostable done");
      for (int k = 0; k < 4; k++) begin
         wr(`PTS_OFF_LIMIT, {3'h0, lm[k]});
         setup(`PTS_CS_FOSC, 255, 0, 0);
         for (int h = 0; h < 2; h++) begin
            ers[3] <= lh[k] ^ (h == 1);
            repeat (8) @(posedge clk);
            rd(`PTS_OFF_COUNT, v);
            repeat (20) @(posedge clk);
            rd(`PTS_OFF_COUNT, d);
            cmp("level hold", h == 0, v === d);
         end
      end
      for (int k = 3; k < 6; k++) begin
         ers[3] <= (k == 5);
         wr(`PTS_OFF_LIMIT, 8'(k));
         setup(`PTS_CS_FOSC, 255, 0, 0);
         dbg <= 1'b1;
         repeat (60) @(posedge clk);
         ers[3] <= ~ers[3];
         repeat (10) @(posedge clk);
         ers[3] <= ~ers[3];
         rd(`PTS_OFF_COUNT, d);
         cmp("debug ignores", 0, d < 8'h10);
         dbg <= 1'b0;
         repeat (60) @(posedge clk);
         ers[3] <= ~ers[3];
         repeat (8) @(posedge clk);
         rd(`PTS_OFF_COUNT, d);
         cmp("edge reset", 1, d < 8'h10);
      end
      $display("test trigger modes done");
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk(`PTS_OFF_COUNT, `PTS_COUNT_RST, "count");
      chk(`PTS_OFF_MATCH, `PTS_MATCH_RST, "match");
      chk(`PTS_OFF_CTRL, `PTS_CTRL_RST, "ctrl");
      $display("test reset done");
      results();
   end

   // Run needs well under this many cycles; a hang ends here
   initial begin
      #(25 * 95000);
      fails++;
      results();
   end
endmodule
